//--- verilog/cmd_word_core.sv
// serial command decoder, register space and output word formatter
`timescale 1ns/1ps
`default_nettype none
module cmd_word_core (
    // system side
    input wire logic sys_clk,
    input wire logic rst,
    // serial link, link-clocked
    input wire logic link_clk,
    input wire logic select_and_convert,
    input wire logic serial_in,
    output logic serial_out_lanes,
    output logic serial_out_en,
    // configuration and status
    input wire cmd_word_pkg::output_word_control_t ctl,
    input wire logic [31:0] fixed_pattern,
    input wire cmd_word_pkg::conv_status_t status,
    // register space view
    input wire logic [8:0] peek_addr,
    output logic [7:0] peek_data,
    output logic [31:0] next_word,
    output logic cmd_done
);
    ////////////////////////////////////////////////////////////////
    // link domain: shift register and clock counter
    logic [31:0] in_sr_r;
    logic [5:0] clk_cnt_r;
    logic [31:0] out_sr_r;

    // select is timed by the host against this clock, so the link side reads it as is;
    // a synchroniser here would swallow the first bits of every frame

    // input capture on host clock only, never on sys_clk
    always_ff @(posedge link_clk) begin
        if (select_and_convert) begin
            clk_cnt_r <= '0;
            in_sr_r <= cmd_word_pkg::ZERO_WORD;
        end else begin
            in_sr_r <= {in_sr_r[30:0], serial_in};
            if (clk_cnt_r != cmd_word_pkg::FULL_COUNT)
                clk_cnt_r <= clk_cnt_r + 6'h01;
        end
    end

    // output shift: word loaded while select high, msb first
    always_ff @(posedge link_clk) begin
        if (select_and_convert)
            out_sr_r <= next_word;
        else
            out_sr_r <= {out_sr_r[30:0], 1'b0};
    end
    assign serial_out_lanes = out_sr_r[31];
    assign serial_out_en = ~select_and_convert;

    ////////////////////////////////////////////////////////////////
    // frame end crossing: select is a pin, two flops into sys_clk
    logic cs_s1_r, cs_s2_r, cs_s3_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
        end else begin
            cs_s1_r <= select_and_convert;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
        end
    end
    // link state changes only on link_clk edges, which clear it while select is high; with none arriving, sampling it here is stable
    logic frame_end;
    assign frame_end = cs_s2_r & ~cs_s3_r;

    ////////////////////////////////////////////////////////////////
    // decode
    logic [31:0] cmd;
    logic full_frame;
    logic [4:0] op;
    logic [1:0] sub;
    logic [8:0] haddr;
    logic [15:0] dat;
    assign cmd = in_sr_r;
    assign full_frame = (clk_cnt_r == cmd_word_pkg::FULL_COUNT);
    assign op = cmd[cmd_word_pkg::OP_MSB:cmd_word_pkg::OP_LSB];
    assign sub = cmd[cmd_word_pkg::SUB_MSB:cmd_word_pkg::SUB_LSB];
    assign haddr = {cmd[cmd_word_pkg::ADDR_MSB:cmd_word_pkg::ADDR_LSB+1], 1'b0};
    assign dat = cmd[15:0];

    logic exec;
    assign exec = frame_end & full_frame;

    ////////////////////////////////////////////////////////////////
    // register space, byte wide
    logic [7:0] regs_r [0:511];
    logic [7:0] hi_nxt, lo_nxt;
    logic wr_hi, wr_lo;
    logic [7:0] cur_hi, cur_lo;
    assign cur_lo = regs_r[haddr];
    assign cur_hi = regs_r[haddr | 9'h001];

    // opcode actions; anything else including all zero is a no-op
    always_comb begin
        hi_nxt = cur_hi;
        lo_nxt = cur_lo;
        wr_hi = 1'b0;
        wr_lo = 1'b0;
        case (op)
            cmd_word_pkg::OP_BIT_CLEAR_HALF: begin
                hi_nxt = cur_hi & ~dat[15:8];
                lo_nxt = cur_lo & ~dat[7:0];
                wr_hi = 1'b1;
                wr_lo = 1'b1;
            end
            cmd_word_pkg::OP_BIT_SET_HALF: begin
                hi_nxt = cur_hi | dat[15:8];
                lo_nxt = cur_lo | dat[7:0];
                wr_hi = 1'b1;
                wr_lo = 1'b1;
            end
            cmd_word_pkg::OP_WRITE: begin
                hi_nxt = dat[15:8];
                lo_nxt = dat[7:0];
                wr_hi = (sub == cmd_word_pkg::SUB_BOTH) | (sub == cmd_word_pkg::SUB_UPPER);
                wr_lo = (sub == cmd_word_pkg::SUB_BOTH) | (sub == cmd_word_pkg::SUB_LOWER);
            end
            default: begin
                wr_hi = 1'b0;
            end
        endcase
    end

    // the upper byte of a half word sits at the odd address
    always_ff @(posedge sys_clk) begin
        if (exec && wr_hi)
            regs_r[haddr | 9'h001] <= hi_nxt;
        if (exec && wr_lo)
            regs_r[haddr] <= lo_nxt;
    end
    assign peek_data = regs_r[peek_addr];

    ////////////////////////////////////////////////////////////////
    // remember what the next frame returns
    cmd_word_pkg::next_kind_t kind_r;
    logic [8:0] rd_addr_r;
    logic [8:0] raddr;
    assign raddr = cmd[cmd_word_pkg::ADDR_MSB:cmd_word_pkg::ADDR_LSB];
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            kind_r <= cmd_word_pkg::NEXT_CONV;
            rd_addr_r <= 9'h000;
        end else if (frame_end) begin
            kind_r <= cmd_word_pkg::NEXT_CONV;
            if (full_frame && op == cmd_word_pkg::OP_READ_HALF) begin
                kind_r <= cmd_word_pkg::NEXT_HALF;
                rd_addr_r <= haddr;
            end else if (full_frame && op == cmd_word_pkg::OP_READ_BYTE) begin
                kind_r <= cmd_word_pkg::NEXT_BYTE;
                rd_addr_r <= raddr;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst)
            cmd_done <= 1'b0;
        else
            cmd_done <= exec;
    end

    ////////////////////////////////////////////////////////////////
    // conversion word with contiguous flags
    logic [31:0] conv_word;
    always_comb begin
        logic [31:0] w;
        logic [5:0] pos;
        w = cmd_word_pkg::ZERO_WORD;
        w[31:18] = status.result;
        pos = 6'd18;
        if (ctl.append_position_id) begin
            w[pos-1 -: 4] = status.position_id;
            pos = pos - 6'd4;
        end
        if (ctl.append_supply_alarms) begin
            w[pos-1 -: 2] = status.supply_alarms;
            pos = pos - 6'd2;
        end
        if (ctl.append_input_alarms) begin
            w[pos-1 -: 2] = status.input_alarms;
            pos = pos - 6'd2;
        end
        if (ctl.append_range_code) begin
            w[pos-1 -: 4] = status.range_code;
            pos = pos - 6'd4;
        end
        if (ctl.append_parity) begin
            // even parity: upper bit over result, lower over appended flags;
            // lower first, so that it never folds in the upper parity bit
            w[pos-2] = ^w[17:0];
            w[pos-1] = ^status.result;
        end
        conv_word = w;
    end

    // pattern overrides reads, reads override conversion
    always_ff @(posedge sys_clk) begin
        if (rst)
            next_word <= cmd_word_pkg::ZERO_WORD;
        else if (ctl.fixed_pattern_sel)
            next_word <= fixed_pattern;
        else begin
            case (kind_r)
                cmd_word_pkg::NEXT_HALF:
                    next_word <= {regs_r[rd_addr_r | 9'h001], regs_r[rd_addr_r], 16'h0000};
                cmd_word_pkg::NEXT_BYTE:
                    next_word <= {regs_r[rd_addr_r], 24'h000000};
                default:
                    next_word <= conv_word;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks: all on sys_clk; link framing itself is checked from the bench
    logic known_op;
    assign known_op = (op == cmd_word_pkg::OP_BIT_CLEAR_HALF)
        | (op == cmd_word_pkg::OP_READ_HALF)
        | (op == cmd_word_pkg::OP_READ_BYTE)
        | (op == cmd_word_pkg::OP_WRITE)
        | (op == cmd_word_pkg::OP_BIT_SET_HALF);

    // a command only runs after a whole frame of clocks
    chk_exec_needs_full: assert property (@(posedge sys_clk) disable iff (rst)
        cmd_done |-> $past(full_frame)) else $error("command ran without full frame");
    // frame end is a one-cycle event, so done never stretches
    chk_done_one_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        cmd_done |=> !cmd_done) else $error("done held longer than one cycle");
    chk_pattern_wins: assert property (@(posedge sys_clk) disable iff (rst)
        ctl.fixed_pattern_sel ##1 ctl.fixed_pattern_sel |-> next_word == $past(fixed_pattern))
        else $error("fixed pattern not selected");
    chk_byte_read_zeros: assert property (@(posedge sys_clk) disable iff (rst)
        (kind_r == cmd_word_pkg::NEXT_BYTE && !ctl.fixed_pattern_sel) |=> next_word[23:0] == 24'h0)
        else $error("byte read low bits not zero");
    chk_half_read_zeros: assert property (@(posedge sys_clk) disable iff (rst)
        (kind_r == cmd_word_pkg::NEXT_HALF && !ctl.fixed_pattern_sel) |=> next_word[15:0] == 16'h0)
        else $error("half read low bits not zero");
    chk_half_addr_even: assert property (@(posedge sys_clk) disable iff (rst)
        kind_r == cmd_word_pkg::NEXT_HALF |-> rd_addr_r[0] == 1'b0)
        else $error("half read address odd");
    chk_no_op_kind: assert property (@(posedge sys_clk) disable iff (rst)
        (frame_end && !full_frame) |=> kind_r == cmd_word_pkg::NEXT_CONV)
        else $error("short frame selected a read");
    chk_conv_top: assert property (@(posedge sys_clk) disable iff (rst)
        (kind_r == cmd_word_pkg::NEXT_CONV && !ctl.fixed_pattern_sel) |=>
        next_word[31:18] == $past(status.result)) else $error("result not on top");
    chk_no_flag_zero: assert property (@(posedge sys_clk) disable iff (rst)
        (kind_r == cmd_word_pkg::NEXT_CONV && !ctl.fixed_pattern_sel && ctl == '0) |=>
        next_word[17:0] == 18'h0) else $error("unused bits not zero");
    // register effects are visible one edge after the command runs
    chk_set_bits_land: assert property (@(posedge sys_clk) disable iff (rst)
        (exec && op == cmd_word_pkg::OP_BIT_SET_HALF) |=>
        ({regs_r[$past(haddr) | 9'h001], regs_r[$past(haddr)]} & $past(dat)) == $past(dat))
        else $error("set bits not set");
    chk_clear_bits_land: assert property (@(posedge sys_clk) disable iff (rst)
        (exec && op == cmd_word_pkg::OP_BIT_CLEAR_HALF) |=>
        ({regs_r[$past(haddr) | 9'h001], regs_r[$past(haddr)]} & $past(dat)) == 16'h0000)
        else $error("cleared bits still set");
    chk_upper_only: assert property (@(posedge sys_clk) disable iff (rst)
        (exec && op == cmd_word_pkg::OP_WRITE && sub == cmd_word_pkg::SUB_UPPER) |=>
        regs_r[$past(haddr)] == $past(cur_lo)) else $error("upper write touched lower byte");
    chk_lower_only: assert property (@(posedge sys_clk) disable iff (rst)
        (exec && op == cmd_word_pkg::OP_WRITE && sub == cmd_word_pkg::SUB_LOWER) |=>
        regs_r[$past(haddr) | 9'h001] == $past(cur_hi))
        else $error("lower write touched upper byte");
    // opcodes outside the table leave the addressed pair alone; the all-zero word
    // is left out, as the pair at address zero holds nothing known in a fresh part
    chk_unknown_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        (exec && !known_op && op != 5'h00) |=>
        regs_r[$past(haddr)] == $past(cur_lo) && regs_r[$past(haddr) | 9'h001] == $past(cur_hi))
        else $error("unknown command changed a register");
    cov_full_cmd: cover property (@(posedge sys_clk) disable iff (rst) exec);
    cov_half_read: cover property (@(posedge sys_clk) disable iff (rst)
        kind_r == cmd_word_pkg::NEXT_HALF);
    cov_byte_read: cover property (@(posedge sys_clk) disable iff (rst)
        kind_r == cmd_word_pkg::NEXT_BYTE);
    cov_pattern_read: cover property (@(posedge sys_clk) disable iff (rst)
        ctl.fixed_pattern_sel && kind_r != cmd_word_pkg::NEXT_CONV);
    cov_short: cover property (@(posedge sys_clk) disable iff (rst) frame_end && !full_frame);
endmodule
`default_nettype wire

//--- verilog/cmd_word_pkg.sv
// package: command opcodes, output word layout and register space constants
package cmd_word_pkg;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned HALF_W = 16;
    localparam int unsigned RES_W = 14;
    localparam int unsigned REG_BYTES = 512;
    localparam int unsigned CNT_W = 6;
    // opcode field positions
    localparam int unsigned OP_MSB = 31;
    localparam int unsigned OP_LSB = 27;
    localparam int unsigned SUB_MSB = 26;
    localparam int unsigned SUB_LSB = 25;
    localparam int unsigned ADDR_MSB = 24;
    localparam int unsigned ADDR_LSB = 16;
    // opcodes
    localparam logic [4:0] OP_BIT_CLEAR_HALF = 5'h18;
    localparam logic [4:0] OP_READ_HALF = 5'h19;
    localparam logic [4:0] OP_READ_BYTE = 5'h09;
    localparam logic [4:0] OP_WRITE = 5'h1a;
    localparam logic [4:0] OP_BIT_SET_HALF = 5'h1b;
    localparam logic [1:0] SUB_BOTH = 2'h0;
    localparam logic [1:0] SUB_UPPER = 2'h1;
    localparam logic [1:0] SUB_LOWER = 2'h2;
    localparam logic [CNT_W-1:0] FULL_COUNT = 6'h20;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [7:0] REG_RESET = 8'h00;
    // flag field widths
    localparam int unsigned POS_W = 4;
    localparam int unsigned ALM_W = 2;
    localparam int unsigned RNG_W = 4;
    localparam int unsigned PAR_W = 2;

    // what the output word control selects
    typedef struct packed {
        logic fixed_pattern_sel;
        logic append_position_id;
        logic append_supply_alarms;
        logic append_input_alarms;
        logic append_range_code;
        logic append_parity;
    } output_word_control_t;

    // conversion result and the status fields that may be appended
    typedef struct packed {
        logic [RES_W-1:0] result;
        logic [POS_W-1:0] position_id;
        logic [ALM_W-1:0] supply_alarms;
        logic [ALM_W-1:0] input_alarms;
        logic [RNG_W-1:0] range_code;
    } conv_status_t;

    typedef enum logic [1:0] {
        NEXT_CONV = 2'b00,
        NEXT_HALF = 2'b01,
        NEXT_BYTE = 2'b10
    } next_kind_t;
endpackage

//--- dv/host_model.sv
// host-side link model: frames commands and captures the output word
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // link pins
    output logic link_clk,
    output logic select_and_convert,
    output logic serial_in,
    input wire logic serial_out_lanes
);
    // idle: clock parked low, frame closed
    initial begin
        link_clk = 1'b0;
        select_and_convert = 1'b1;
        serial_in = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one frame of n clocks; the last 32 bits carry cmd, ones pad in front
    task automatic frame(input logic [31:0] cmd, input int n, output logic [31:0] got);
        logic [63:0] bits;
        bits = {32'hffff_ffff, cmd};
        got = 32'h0;
        // one edge while closed loads the fresh output word
        #3 link_clk = 1'b1;
        #3 link_clk = 1'b0;
        select_and_convert = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = bits[i];
            #3;
            if (n - 1 - i < 32) got = {got[30:0], serial_out_lanes};
            link_clk = 1'b1;
            #3 link_clk = 1'b0;
        end
        #3 select_and_convert = 1'b1;
        // released line shows the opposite level, never a held value
        serial_in = ~serial_in;
        if (n < 32) got = got << (32 - n);
    endtask
endmodule
`default_nettype wire

//--- dv/cmd_word_core_test.sv
// self-checking bench for the command decoder and output word formatter
`timescale 1ns/1ps
`default_nettype none
module cmd_word_core_test;
    typedef struct packed {
        logic [31:0] cmd;
        cmd_word_pkg::output_word_control_t c;
        logic [6:0] n;
        logic [31:0] exp;
    } row_t;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic link_clk, select_and_convert, serial_in, serial_out_lanes, serial_out_en, cmd_done;
    cmd_word_pkg::output_word_control_t ctl = '0;
    logic [31:0] fixed_pattern = 32'hc3a5_0f96;
    cmd_word_pkg::conv_status_t status = '{14'h2a5c, 4'h9, 2'h2, 2'h1, 4'h6};
    logic [8:0] peek_addr = 9'h004;
    logic [7:0] peek_data;
    logic [31:0] next_word, got, prev, e, m;
    int fail_count = 0;
    int comparisons = 0;
    int done_seen = 0;
    int full_frames = 0;
    row_t rows [16];
    always #5 sys_clk = ~sys_clk;
    // done pulses counted at the falling edge, where they are settled
    always @(negedge sys_clk) if (cmd_done === 1'b1) done_seen++;
    cmd_word_core DUT (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
        .select_and_convert(select_and_convert), .serial_in(serial_in),
        .serial_out_lanes(serial_out_lanes), .serial_out_en(serial_out_en), .ctl(ctl),
        .fixed_pattern(fixed_pattern), .status(status), .peek_addr(peek_addr),
        .peek_data(peek_data), .next_word(next_word), .cmd_done(cmd_done));
    host_model host (.link_clk(link_clk), .select_and_convert(select_and_convert),
        .serial_in(serial_in), .serial_out_lanes(serial_out_lanes));
    ////////////////////////////////////////////////////////////////////////////
    // conversion word with flags packed downwards from bit 17
    function automatic logic [31:0] conv_word(input cmd_word_pkg::output_word_control_t c);
        logic [31:0] w;
        logic lo;
        int p;
        w = {status.result, 18'h0};
        p = 18;
        if (c.append_position_id) begin
            p -= 4;
            w[p +: 4] = status.position_id;
        end
        if (c.append_supply_alarms) begin
            p -= 2;
            w[p +: 2] = status.supply_alarms;
        end
        if (c.append_input_alarms) begin
            p -= 2;
            w[p +: 2] = status.input_alarms;
        end
        if (c.append_range_code) begin
            p -= 4;
            w[p +: 4] = status.range_code;
        end
        // lower parity first, so it never covers the parity bits themselves
        if (c.append_parity) begin
            lo = ^w[17:0];
            p -= 2;
            w[p + 1] = ^status.result;
            w[p] = lo;
        end
        return w;
    endfunction
    task automatic check_word(input string what, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, x, g);
        end
    endtask
    task automatic check_byte(input string what, input logic [7:0] x, input logic [7:0] g);
        comparisons++;
        if (g !== x) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, x, g);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // rows: command, control, clocks, expected next word (zero: conversion word)
    initial begin
        rows[0] = '{32'hd005_a55a, 6'h00, 7'd32, 32'h0};
        rows[1] = '{32'hc805_0000, 6'h00, 7'd32, 32'ha55a_0000};
        rows[2] = '{32'h4805_0000, 6'h00, 7'd32, 32'ha500_0000};
        rows[3] = '{32'hd804_0f00, 6'h00, 7'd32, 32'h0};
        rows[4] = '{32'hc004_00f0, 6'h00, 7'd32, 32'h0};
        rows[5] = '{32'hc804_0000, 6'h00, 7'd32, 32'haf0a_0000};
        rows[6] = '{32'hd204_3344, 6'h00, 7'd32, 32'h0};
        rows[7] = '{32'hd404_5566, 6'h00, 7'd32, 32'h0};
        rows[8] = '{32'hc804_0000, 6'h00, 7'd32, 32'h3366_0000};
        rows[9] = '{32'h0000_0000, 6'h1f, 7'd32, 32'h0};
        rows[10] = '{32'hf804_d004, 6'h0b, 7'd32, 32'h0};
        rows[11] = '{32'h0000_0000, 6'h00, 7'd16, 32'h0};
        rows[12] = '{32'hc804_0000, 6'h00, 7'd32, 32'h3366_0000};
        rows[13] = '{32'h4804_0000, 6'h00, 7'd40, 32'h6600_0000};
        rows[14] = '{32'hc804_0000, 6'h20, 7'd32, 32'hc3a5_0f96};
        rows[15] = '{32'h0000_0000, 6'h00, 7'd32, 32'h0};
        // the first frame carries the conversion word made right after reset
        prev = conv_word('0);
        repeat (2) @(negedge sys_clk);
        check_word("next word in reset", 32'h0, next_word);
        check_byte("done in reset", 8'h00, {7'h00, cmd_done});
        rst <= 1'b0;
        @(negedge sys_clk);
        check_word("next word after reset", conv_word('0), next_word);
        repeat (4) @(negedge sys_clk);
        for (int i = 0; i < 16; i++) begin
            fork
                host.frame(rows[i].cmd, rows[i].n, got);
                begin
                    @(negedge select_and_convert);
                    #1;
                    check_byte("enable in frame", 8'h01, {7'h00, serial_out_en});
                end
            join
            if (rows[i].n >= 7'd32) full_frames++;
            @(negedge sys_clk) ctl <= rows[i].c;
            check_byte("enable between frames", 8'h00, {7'h00, serial_out_en});
            m = (rows[i].n >= 32) ? 32'hffff_ffff : ~(32'hffff_ffff >> rows[i].n);
            check_word("shifted word", prev & m, got & m);
            repeat (10) @(negedge sys_clk);
            e = (rows[i].exp === 32'h0) ? conv_word(rows[i].c) : rows[i].exp;
            check_word("next word", e, next_word);
            prev = e;
        end
        // a read still pending when reset hits gives way to the conversion word
        host.frame(32'hc804_0000, 32, got);
        full_frames++;
        @(negedge sys_clk);
        check_word("shifted word", prev, got);
        repeat (10) @(negedge sys_clk);
        check_word("read before reset", 32'h3366_0000, next_word);
        rst <= 1'b1;
        repeat (2) @(negedge sys_clk);
        check_word("next word in second reset", 32'h0, next_word);
        rst <= 1'b0;
        @(negedge sys_clk);
        check_word("next word after second reset", conv_word('0), next_word);
        check_byte("done pulses", full_frames[7:0], done_seen[7:0]);
        // register bytes seen directly, both halves of the pair
        check_byte("byte 004", 8'h66, peek_data);
        peek_addr <= 9'h005;
        @(negedge sys_clk);
        check_byte("byte 005", 8'h33, peek_data);
        report_and_stop();
    end
    // watchdog, well beyond seventeen frames
    initial begin
        #50us;
        fail_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
